// file: design/vport_irq_regs.svh
/*
  Register offsets, field positions and reset values of the video port interrupt acknowledge block.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
`ifndef VPORT_IRQ_REGS_SVH
`define VPORT_IRQ_REGS_SVH
`define ADDR_W             8
`define OFS_FLAGS          8'h00
`define OFS_ACK            8'h04
`define OFS_MASK           8'h08
`define OFS_CTRL           8'h0c
`define OFS_LINE_FLAGS     8'h10
`define BIT_CH0            0
`define BIT_CH1            1
`define BIT_CH2            2
`define BIT_CH3            3
`define BIT_ERR            4
`define NFLAGS             5
`define FMT_LSB            0
`define FMT_W              3
`define FMT_FRAME          3'h0
`define FMT_RAW            3'h3
`define RST_FLAGS          5'h00
`define RST_MASK           5'h00
`define RST_FMT            3'h0
`define RST_LINE           1'h0
`define RST_ACK            1'h0
`define RST_RDAT           32'h00000000
`define SEL_LANE           0
`endif

// file: design/vport_irq_pkg.sv
/*
  Types shared by the video port interrupt acknowledge block.
  Assumes the register header is included first.
*/
`include "vport_irq_regs.svh"
package vport_irq_pkg;
  typedef struct packed {
    logic [`ADDR_W-1:0] adr;
    logic [31:0]        dat;
    logic [3:0]         sel;
    logic               we;
    logic               cyc;
    logic               stb;
  } wb_req_t;

  typedef struct packed {
    logic [31:0] dat;
    logic        ack;
    logic        err;
  } wb_rsp_t;

  typedef struct packed {
    logic [`NFLAGS-1:0] flags;
    logic               line_flag;
    logic [`NFLAGS-1:0] mask;
    logic [`FMT_W-1:0]  fmt;
    logic               ack;
    logic [31:0]        rdat;
  } state_t;
endpackage

// file: design/video_port_irq_status_clear.sv
/*
  Interrupt flag register, mask, format control and the write-only acknowledge register of a video port,
  reached over classic Wishbone. Assumes event inputs are one-cycle pulses synchronous to clk_i.
*/
// Decided for this implementation: the register addresses and the Wishbone slave port.
// Function
// - Write one bit 4 clears error flag.
// - Write one bit 3 clears channel 3.
// - Write one bit 2 clears channel 2.
// - Write one bit 1 clears channel 1, or the line flag in raw format.
// - Write one bit 0 clears channel 0.
// - Acknowledge bits are strobes, read as zero.
// - Raw format: bit 1 clears line flag.
// - Frame format: bit 1 clears frame flag.
`timescale 1ns/1ps
`include "vport_irq_regs.svh"
module video_port_irq_status_clear (
  // Clock and reset.
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Wishbone slave.
  input  wire vport_irq_pkg::wb_req_t  wb_i,
  output vport_irq_pkg::wb_rsp_t       wb_o,
  // Event sources, one-cycle pulses.
  input  wire logic [`NFLAGS-1:0]      frame_evt_i,
  input  wire logic                    line_evt_i,
  // Interrupt and status.
  output logic                         irq_o,
  output logic [`NFLAGS-1:0]           flags_o
);
  import vport_irq_pkg::*;

  // Registered state and the value it takes at the next edge.
  state_t             st;
  state_t             next_st;

  // Bus decode.
  logic               wr_acc;
  logic               rd_acc;
  logic               ack_wr;
  logic               mask_wr;
  logic               ctrl_wr;

  // Routing of the acknowledge bits onto the flags.
  logic               raw_mode;
  logic [`NFLAGS-1:0] ack_bits;
  logic [`NFLAGS-1:0] frame_clr;
  logic               line_clr;
  logic               irq_frame;
  logic               irq_line;

  // Widens the flag field to a bus word.
  function automatic logic [31:0] zext5(input logic [`NFLAGS-1:0] v);
    zext5 = {27'h0000000, v};
  endfunction

  // Widens the format field to a bus word.
  function automatic logic [31:0] zext_fmt(input logic [`FMT_W-1:0] v);
    zext_fmt = {29'h00000000, v};
  endfunction

  // Widens the line flag to a bus word.
  function automatic logic [31:0] zext_line(input logic v);
    zext_line = {31'h00000000, v};
  endfunction

  // True when a bus address selects the given register.
  function automatic logic hits(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
    hits = (a == ofs);
  endfunction

  // State of every register after reset.
  function automatic state_t reset_state();
    state_t s;
    s           = '0;
    s.flags     = `RST_FLAGS;
    s.line_flag = `RST_LINE;
    s.mask      = `RST_MASK;
    s.fmt       = `RST_FMT;
    s.ack       = `RST_ACK;
    s.rdat      = `RST_RDAT;
    reset_state = s;
  endfunction

  assign wr_acc   = wb_i.cyc && wb_i.stb && wb_i.we && !st.ack;
  assign rd_acc   = wb_i.cyc && wb_i.stb && !wb_i.we && !st.ack;
  assign ack_wr   = wr_acc && wb_i.sel[`SEL_LANE] && hits(wb_i.adr, `OFS_ACK);
  assign mask_wr  = wr_acc && wb_i.sel[`SEL_LANE] && hits(wb_i.adr, `OFS_MASK);
  assign ctrl_wr  = wr_acc && wb_i.sel[`SEL_LANE] && hits(wb_i.adr, `OFS_CTRL);
  assign raw_mode = (st.fmt == `FMT_RAW);
  assign ack_bits = ack_wr ? wb_i.dat[`NFLAGS-1:0] : `RST_FLAGS;

  // Bit 1 is steered by the capture format; the other bits always hit their own flag.
  always_comb begin
    frame_clr           = ack_bits;
    frame_clr[`BIT_CH1] = ack_bits[`BIT_CH1] && !raw_mode;
    line_clr            = ack_bits[`BIT_CH1] && raw_mode;
  end

  // One next-state process: flags, mask, format and the bus answer.
  always_comb begin
    next_st           = st;
    next_st.ack       = wr_acc || rd_acc;
    next_st.rdat      = `RST_RDAT;
    next_st.flags     = (st.flags & ~frame_clr) | frame_evt_i;
    next_st.line_flag = (st.line_flag && !line_clr) || line_evt_i;
    if (mask_wr) begin
      next_st.mask = wb_i.dat[`NFLAGS-1:0];
    end
    if (ctrl_wr) begin
      next_st.fmt = wb_i.dat[`FMT_LSB +: `FMT_W];
    end
    if (rd_acc) begin
      unique case (wb_i.adr)
        `OFS_FLAGS:      next_st.rdat = zext5(st.flags);
        `OFS_ACK:        next_st.rdat = `RST_RDAT;
        `OFS_MASK:       next_st.rdat = zext5(st.mask);
        `OFS_CTRL:       next_st.rdat = zext_fmt(st.fmt);
        `OFS_LINE_FLAGS: next_st.rdat = zext_line(st.line_flag);
        default:         next_st.rdat = `RST_RDAT;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= reset_state();
    end else begin
      st <= next_st;
    end
  end

  assign irq_frame = |(st.flags & st.mask);
  assign irq_line  = st.line_flag && st.mask[`BIT_CH1];
  assign wb_o.dat  = st.rdat;
  assign wb_o.ack  = st.ack;
  assign wb_o.err  = 1'b0;
  assign flags_o   = st.flags;
  assign irq_o     = irq_frame || irq_line;

  // Checks on the flags, the bus answer and the interrupt.
  a_err_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && wb_i.dat[`BIT_ERR] && !frame_evt_i[`BIT_ERR])
      |=> !st.flags[`BIT_ERR])
    else $error("Error flag not cleared.");

  a_err_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && !wb_i.dat[`BIT_ERR] && st.flags[`BIT_ERR])
      |=> st.flags[`BIT_ERR])
    else $error("Error flag cleared by a zero.");

  a_err_only_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_acc && !ack_wr && st.flags[`BIT_ERR])
      |=> st.flags[`BIT_ERR])
    else $error("Error flag cleared by another write.");

  a_ch3_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && wb_i.dat[`BIT_CH3] && !frame_evt_i[`BIT_CH3])
      |=> !st.flags[`BIT_CH3])
    else $error("Channel 3 flag not cleared.");

  a_ch3_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && !wb_i.dat[`BIT_CH3] && st.flags[`BIT_CH3])
      |=> st.flags[`BIT_CH3])
    else $error("Channel 3 flag cleared by a zero.");

  a_ch3_only_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_acc && !ack_wr && st.flags[`BIT_CH3])
      |=> st.flags[`BIT_CH3])
    else $error("Channel 3 flag cleared by another write.");

  a_ch3_race: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && wb_i.dat[`BIT_CH3] && frame_evt_i[`BIT_CH3])
      |=> st.flags[`BIT_CH3])
    else $error("Channel 3 event lost against clear.");

  a_ch2_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && wb_i.dat[`BIT_CH2] && !frame_evt_i[`BIT_CH2])
      |=> !st.flags[`BIT_CH2])
    else $error("Channel 2 flag not cleared.");

  a_ch2_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && !wb_i.dat[`BIT_CH2] && st.flags[`BIT_CH2])
      |=> st.flags[`BIT_CH2])
    else $error("Channel 2 flag cleared by a zero.");

  a_ch2_only_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_acc && !ack_wr && st.flags[`BIT_CH2])
      |=> st.flags[`BIT_CH2])
    else $error("Channel 2 flag cleared by another write.");

  a_ch2_race: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && wb_i.dat[`BIT_CH2] && frame_evt_i[`BIT_CH2])
      |=> st.flags[`BIT_CH2])
    else $error("Channel 2 event lost against clear.");

  a_ch1_frame: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && wb_i.dat[`BIT_CH1] && st.fmt == `FMT_FRAME && !frame_evt_i[`BIT_CH1])
      |=> !st.flags[`BIT_CH1])
    else $error("Channel 1 frame flag not cleared.");

  a_ch1_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && !wb_i.dat[`BIT_CH1] && st.flags[`BIT_CH1])
      |=> st.flags[`BIT_CH1])
    else $error("Channel 1 flag cleared by a zero.");

  a_ch1_only_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_acc && !ack_wr && st.flags[`BIT_CH1])
      |=> st.flags[`BIT_CH1])
    else $error("Channel 1 flag cleared by another write.");

  a_ch1_race: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && wb_i.dat[`BIT_CH1] && frame_evt_i[`BIT_CH1])
      |=> st.flags[`BIT_CH1])
    else $error("Channel 1 event lost against clear.");

  a_ch0_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && wb_i.dat[`BIT_CH0] && !frame_evt_i[`BIT_CH0])
      |=> !st.flags[`BIT_CH0])
    else $error("Channel 0 flag not cleared.");

  a_ch0_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && !wb_i.dat[`BIT_CH0] && st.flags[`BIT_CH0])
      |=> st.flags[`BIT_CH0])
    else $error("Channel 0 flag cleared by a zero.");

  a_ch0_only_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_acc && !ack_wr && st.flags[`BIT_CH0])
      |=> st.flags[`BIT_CH0])
    else $error("Channel 0 flag cleared by another write.");

  a_ch0_race: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && wb_i.dat[`BIT_CH0] && frame_evt_i[`BIT_CH0])
      |=> st.flags[`BIT_CH0])
    else $error("Channel 0 event lost against clear.");

  a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_evt_i[`BIT_ERR]
      |=> st.flags[`BIT_ERR])
    else $error("Event lost against clear.");

  a_raw_line: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && wb_i.dat[`BIT_CH1] && st.fmt == `FMT_RAW && !line_evt_i)
      |=> (!st.line_flag && st.flags[`BIT_CH1] == $past(st.flags[`BIT_CH1] || frame_evt_i[`BIT_CH1])))
    else $error("Raw mode clear acted on wrong flag.");

  a_line_zero_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (!(ack_wr && wb_i.dat[`BIT_CH1]) && st.line_flag)
      |=> st.line_flag)
    else $error("Line flag lost without a clear.");

  a_line_frame_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_wr && st.fmt == `FMT_FRAME && st.line_flag)
      |=> st.line_flag)
    else $error("Frame mode clear hit the line flag.");

  a_line_set: assert property (@(posedge clk_i) disable iff (rst_i)
    line_evt_i
      |=> st.line_flag)
    else $error("Line event lost.");

  a_bus_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_i.cyc && wb_i.stb && !wb_o.ack)
      |=> wb_o.ack)
    else $error("Bus request not answered.");

  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_o.ack
      |=> !wb_o.ack)
    else $error("Bus answer longer than one cycle.");

  a_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_o.ack
      |-> $past(wb_i.cyc && wb_i.stb))
    else $error("Bus answer without a request.");

  a_write_no_data: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_acc
      |=> (wb_o.dat == `RST_RDAT))
    else $error("Write answer carries data.");

  a_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_o.ack
      |-> (wb_o.dat == `RST_RDAT))
    else $error("Read data outside the answer cycle.");

  a_ack_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_acc && hits(wb_i.adr, `OFS_ACK))
      |=> (wb_o.ack && wb_o.dat == `RST_RDAT))
    else $error("Acknowledge register read not zero.");

  a_read_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_acc && hits(wb_i.adr, `OFS_FLAGS))
      |=> (wb_o.dat == zext5($past(st.flags))))
    else $error("Flag register read wrong.");

  a_read_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_acc && hits(wb_i.adr, `OFS_MASK))
      |=> (wb_o.dat == zext5($past(st.mask))))
    else $error("Mask register read wrong.");

  a_read_ctrl: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_acc && hits(wb_i.adr, `OFS_CTRL))
      |=> (wb_o.dat == zext_fmt($past(st.fmt))))
    else $error("Control register read wrong.");

  a_read_line: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_acc && hits(wb_i.adr, `OFS_LINE_FLAGS))
      |=> (wb_o.dat == zext_line($past(st.line_flag))))
    else $error("Line flag read wrong.");

  a_read_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_acc && !hits(wb_i.adr, `OFS_FLAGS) && !hits(wb_i.adr, `OFS_ACK) && !hits(wb_i.adr, `OFS_MASK)
      && !hits(wb_i.adr, `OFS_CTRL) && !hits(wb_i.adr, `OFS_LINE_FLAGS)) |=> (wb_o.dat == `RST_RDAT))
    else $error("Unmapped read not zero.");

  a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
    mask_wr
      |=> (st.mask == $past(wb_i.dat[`NFLAGS-1:0])))
    else $error("Mask write lost.");

  a_fmt_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr
      |=> (st.fmt == $past(wb_i.dat[`FMT_LSB +: `FMT_W])))
    else $error("Format write lost.");

  a_no_retain: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_wr
      |=> (st.mask == $past(st.mask) && st.fmt == $past(st.fmt)))
    else $error("Acknowledge write stored a value.");

  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(st.flags & st.mask))
      |-> irq_o)
    else $error("Interrupt not raised.");

  a_irq_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (!(|(st.flags & st.mask)) && !(st.line_flag && st.mask[`BIT_CH1]))
      |-> !irq_o)
    else $error("Interrupt raised with nothing pending.");

  a_reset_state: assert property (@(posedge clk_i)
    rst_i
      |=> (st.flags == `RST_FLAGS && st.mask == `RST_MASK && st.fmt == `RST_FMT && !wb_o.ack))
    else $error("Reset state wrong.");

endmodule // video_port_irq_status_clear

// file: dv/test_video_port_irq_status_clear.sv
/*
  Self-checking bench for the interrupt acknowledge block.
  Assumes the register header and package are compiled first.
*/
`timescale 1ns/1ps
`include "vport_irq_regs.svh"
module test_video_port_irq_status_clear;
  import vport_irq_pkg::*;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  wb_req_t            wb_i = '0;
  wb_rsp_t            wb_o;
  logic [`NFLAGS-1:0] frame_evt_i = '0;
  logic               line_evt_i = 1'b0;
  logic               irq_o;
  logic [`NFLAGS-1:0] flags_o;
  logic [31:0]        rd;
  int                 num_errors = 0;
  int                 num_checks = 0;

  video_port_irq_status_clear dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
    .frame_evt_i(frame_evt_i), .line_evt_i(line_evt_i), .irq_o(irq_o), .flags_o(flags_o));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [4:0] ev);
    @(posedge clk_i);
    wb_i <= '{adr: a, dat: d, sel: 4'hf, we: w, cyc: 1'b1, stb: 1'b1};
    frame_evt_i <= ev;
    @(posedge clk_i);
    frame_evt_i <= '0;
    while (wb_o.ack !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = wb_o.dat;
    wb_i.cyc <= 1'b0;
    wb_i.stb <= 1'b0;
  endtask

  task automatic pulse(input logic [4:0] ev, input logic ln);
    @(posedge clk_i);
    frame_evt_i <= ev;
    line_evt_i <= ln;
    @(posedge clk_i);
    frame_evt_i <= '0;
    line_evt_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic t_clear();
    bus(1'b1, `OFS_MASK, 32'h1f, 5'h00);
    pulse(5'h1f, 1'b0);
    chk(irq_o, 32'h1);
    bus(1'b1, `OFS_ACK, 32'hffff_ffe0, 5'h00);
    chk(flags_o, 32'h1f);
    for (int b = 0; b < `NFLAGS; b++) begin
      bus(1'b1, `OFS_ACK, 32'h1 << b, 5'h00);
      chk(flags_o, 32'h1f & ~((32'h2 << b) - 1));
    end
    chk(irq_o, 32'h0);
    $display("test clear done");
  endtask

  task automatic t_readback();
    bus(1'b1, `OFS_ACK, 32'h1f, 5'h00);
    bus(1'b0, `OFS_ACK, 32'h0, 5'h00);
    chk(rd, 32'h0);
    bus(1'b0, 8'h40, 32'h0, 5'h00);
    chk(rd, 32'h0);
    bus(1'b0, `OFS_MASK, 32'h0, 5'h00);
    chk(rd, 32'h1f);
    chk(wb_o.err, 32'h0);
    $display("test readback done");
  endtask

  task automatic t_format();
    bus(1'b1, `OFS_CTRL, 32'h3, 5'h00);
    pulse(5'h02, 1'b1);
    bus(1'b1, `OFS_ACK, 32'h2, 5'h00);
    chk(flags_o, 32'h2);
    bus(1'b0, `OFS_LINE_FLAGS, 32'h0, 5'h00);
    chk(rd, 32'h0);
    bus(1'b1, `OFS_CTRL, 32'h0, 5'h00);
    pulse(5'h00, 1'b1);
    bus(1'b1, `OFS_ACK, 32'h2, 5'h00);
    chk(flags_o, 32'h0);
    bus(1'b0, `OFS_LINE_FLAGS, 32'h0, 5'h00);
    chk(rd, 32'h1);
    $display("test format done");
  endtask

  task automatic t_race();
    bus(1'b1, `OFS_ACK, 32'h11, 5'h11);
    chk(flags_o, 32'h11);
    bus(1'b1, `OFS_ACK, 32'h11, 5'h00);
    chk(flags_o, 32'h0);
    $display("test race done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #20000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_clear();
    t_readback();
    t_format();
    t_race();
    report_and_stop();
  end
endmodule // test_video_port_irq_status_clear
